// ---- src/dtcm_top.sv ----
// Two timer/counters with mode and run control, Wishbone register access
//
// Design decision made here: the Wishbone register port.
`timescale 1ns/1ps

module dtcm_top #(
    parameter int MC_CLKS = dtcm_pkg::MC_CLKS_DEF
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [dtcm_pkg::ADR_W-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // External pins
    input wire logic count_pin_zero_i,
    input wire logic count_pin_one_i,
    input wire logic external_irq0_pin_n_i,
    input wire logic external_irq1_pin_n_i,
    // Vector acknowledges from the interrupt controller
    input wire logic vec_tf0_i,
    input wire logic vec_tf1_i,
    input wire logic vec_ie0_i,
    input wire logic vec_ie1_i,
    // Flags and baud tick
    output logic timer0_overflow_flag_o,
    output logic timer1_overflow_flag_o,
    output logic ext_irq0_flag_o,
    output logic ext_irq1_flag_o,
    output logic timer1_baud_tick_o
);

    localparam logic [3:0] MC_LAST = 4'(MC_CLKS - 1);

    typedef struct packed {
        logic [7:0] run_ctl;
        logic [7:0] mode_sel;
        logic [7:0] t0_lo;
        logic [7:0] t0_hi;
        logic [7:0] t1_lo;
        logic [7:0] t1_hi;
        logic [3:0] mc_cnt;
        logic [1:0] cpin_s1;
        logic [1:0] cpin_s2;
        logic [1:0] irq_s1;
        logic [1:0] irq_s2;
        logic [1:0] irq_prev;
        logic [1:0] cpin_samp;
        logic [1:0] cpin_pend;
        logic ack;
        logic [31:0] rdat;
        logic t1_tick;
    } dtcm_state_s;

    dtcm_state_s st_ff;
    dtcm_state_s nxt_st;

    logic mc_tick;
    logic req;
    logic wr;
    logic [7:0] idx;
    logic [7:0] wdat;
    logic [1:0] m0;
    logic [1:0] m1;
    logic t0_split;
    logic [1:0] src;
    logic en0;
    logic en1;
    logic inc0;
    logic inc1;
    logic inc_hi;
    logic [16:0] r0;
    logic [16:0] r1;
    logic [8:0] hsum;
    logic set_tf0;
    logic set_tf1;
    logic set_ie0;
    logic set_ie1;
    logic [7:0] ctl;

    // One count step; returns {overflow, high, low}
    function automatic logic [16:0] dtcm_step(
        input logic [1:0] mode,
        input logic [7:0] hi,
        input logic [7:0] lo,
        input logic inc
    );
        logic [8:0] p;
        logic [8:0] s;
        logic [16:0] r;
        p = {1'b0, lo & dtcm_pkg::PRESC_MASK} + 9'h001;
        s = 9'h000;
        r = {1'b0, hi, lo};
        if (inc) begin
            case (mode)
                dtcm_pkg::MODE_PRESC: begin
                    // Upper three low bits are left alone; software ignores them
                    s = {1'b0, hi} + {8'h00, p[dtcm_pkg::PRESC_W]};
                    r = {s[8], s[7:0],
                        (lo & ~dtcm_pkg::PRESC_MASK) | (p[7:0] & dtcm_pkg::PRESC_MASK)};
                end
                dtcm_pkg::MODE_FULL: begin
                    r = {1'b0, hi, lo} + 17'h00001;
                end
                dtcm_pkg::MODE_RELOAD: begin
                    if (lo == 8'hFF) begin
                        r = {1'b1, hi, hi};
                    end else begin
                        r = {1'b0, hi, lo + 8'h01};
                    end
                end
                default: begin
                    s = {1'b0, lo} + 9'h001;
                    r = {s[8], hi, s[7:0]};
                end
            endcase
        end
        return r;
    endfunction : dtcm_step

    always_comb begin
        nxt_st = st_ff;
        mc_tick = (st_ff.mc_cnt == MC_LAST);
        nxt_st.mc_cnt = mc_tick ? 4'h0 : st_ff.mc_cnt + 4'h1;

        // Pin synchronisers
        nxt_st.cpin_s1 = {count_pin_one_i, count_pin_zero_i};
        nxt_st.cpin_s2 = st_ff.cpin_s1;
        nxt_st.irq_s1 = {external_irq1_pin_n_i, external_irq0_pin_n_i};
        nxt_st.irq_s2 = st_ff.irq_s1;
        nxt_st.irq_prev = st_ff.irq_s2;

        // Bus decode; answer one cycle after the request, unmapped reads zero
        req = wb_cyc_i & wb_stb_i & ~st_ff.ack;
        wr = req & wb_we_i & wb_sel_i[0];
        idx = wb_adr_i[dtcm_pkg::ADR_W-1:dtcm_pkg::IDX_LSB];
        wdat = wb_dat_i[7:0];
        nxt_st.ack = req;

        // Count pin sampled once per machine cycle, edge used a cycle later
        if (mc_tick) begin
            nxt_st.cpin_samp = st_ff.cpin_s2;
            nxt_st.cpin_pend = st_ff.cpin_samp & ~st_ff.cpin_s2;
        end

        m0 = st_ff.mode_sel[dtcm_pkg::B_M0_HI:dtcm_pkg::B_M0_LO];
        m1 = st_ff.mode_sel[dtcm_pkg::B_M1_HI:dtcm_pkg::B_M1_LO];
        t0_split = (m0 == dtcm_pkg::MODE_SPLIT);

        // Source select: machine cycles or pending pin edge
        src[0] = st_ff.mode_sel[dtcm_pkg::B_SRC0] ? st_ff.cpin_pend[0] : 1'b1;
        src[1] = st_ff.mode_sel[dtcm_pkg::B_SRC1] ? st_ff.cpin_pend[1] : 1'b1;

        // Gate: run bit and (gate clear or irq pin high)
        en0 = st_ff.run_ctl[dtcm_pkg::B_TR0]
            & (~st_ff.mode_sel[dtcm_pkg::B_GATE0] | st_ff.irq_s2[0]);
        en1 = ~st_ff.mode_sel[dtcm_pkg::B_GATE1] | st_ff.irq_s2[1];
        if (m1 == dtcm_pkg::MODE_SPLIT) begin
            en1 = 1'b0;
        end else if (!t0_split) begin
            en1 = en1 & st_ff.run_ctl[dtcm_pkg::B_TR1];
        end
        // With timer 0 split, timer 1 runs on mode and gate alone since its run bit is lent out
        inc0 = mc_tick & en0 & src[0];
        inc1 = mc_tick & en1 & src[1];
        inc_hi = mc_tick & t0_split & st_ff.run_ctl[dtcm_pkg::B_TR1];

        r0 = dtcm_step(m0, st_ff.t0_hi, st_ff.t0_lo, inc0);
        r1 = dtcm_step(m1, st_ff.t1_hi, st_ff.t1_lo, inc1);
        hsum = {1'b0, st_ff.t0_hi} + {8'h00, inc_hi};

        set_tf0 = r0[16];
        set_tf1 = t0_split ? hsum[8] : r1[16];
        nxt_st.t1_tick = r1[16];

        // External irq detect: type set is falling edge, clear is low level
        set_ie0 = st_ff.run_ctl[dtcm_pkg::B_IT0] ? (st_ff.irq_prev[0] & ~st_ff.irq_s2[0])
            : ~st_ff.irq_s2[0];
        set_ie1 = st_ff.run_ctl[dtcm_pkg::B_IT1] ? (st_ff.irq_prev[1] & ~st_ff.irq_s2[1])
            : ~st_ff.irq_s2[1];

        // Count registers; a bus write overrides the step, run bits never touch them
        nxt_st.t0_lo = (wr && idx == dtcm_pkg::IDX_T0_LO) ? wdat : r0[7:0];
        nxt_st.t0_hi = t0_split ? hsum[7:0] : r0[15:8];
        if (wr && idx == dtcm_pkg::IDX_T0_HI) begin
            nxt_st.t0_hi = wdat;
        end
        nxt_st.t1_lo = (wr && idx == dtcm_pkg::IDX_T1_LO) ? wdat : r1[7:0];
        nxt_st.t1_hi = (wr && idx == dtcm_pkg::IDX_T1_HI) ? wdat : r1[15:8];

        if (wr && idx == dtcm_pkg::IDX_MODE_SEL) begin
            nxt_st.mode_sel = wdat;
        end

        // Run control: write, then vector clears, then hardware sets win
        ctl = (wr && idx == dtcm_pkg::IDX_RUN_CTL) ? wdat : st_ff.run_ctl;
        if (vec_tf0_i) begin
            ctl[dtcm_pkg::B_TF0] = 1'b0;
        end
        if (vec_tf1_i) begin
            ctl[dtcm_pkg::B_TF1] = 1'b0;
        end
        if (vec_ie0_i) begin
            ctl[dtcm_pkg::B_IE0] = 1'b0;
        end
        if (vec_ie1_i) begin
            ctl[dtcm_pkg::B_IE1] = 1'b0;
        end
        ctl[dtcm_pkg::B_TF0] = ctl[dtcm_pkg::B_TF0] | set_tf0;
        ctl[dtcm_pkg::B_TF1] = ctl[dtcm_pkg::B_TF1] | set_tf1;
        ctl[dtcm_pkg::B_IE0] = ctl[dtcm_pkg::B_IE0] | set_ie0;
        ctl[dtcm_pkg::B_IE1] = ctl[dtcm_pkg::B_IE1] | set_ie1;
        nxt_st.run_ctl = ctl;

        // Read data, low byte only
        if (req) begin
            case (idx)
                dtcm_pkg::IDX_RUN_CTL: nxt_st.rdat = {24'h000000, st_ff.run_ctl};
                dtcm_pkg::IDX_MODE_SEL: nxt_st.rdat = {24'h000000, st_ff.mode_sel};
                dtcm_pkg::IDX_T0_LO: nxt_st.rdat = {24'h000000, st_ff.t0_lo};
                dtcm_pkg::IDX_T0_HI: nxt_st.rdat = {24'h000000, st_ff.t0_hi};
                dtcm_pkg::IDX_T1_LO: nxt_st.rdat = {24'h000000, st_ff.t1_lo};
                dtcm_pkg::IDX_T1_HI: nxt_st.rdat = {24'h000000, st_ff.t1_hi};
                default: nxt_st.rdat = 32'h00000000;
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_ff <= '0;
            st_ff.run_ctl <= dtcm_pkg::RST_RUN_CTL;
            st_ff.mode_sel <= dtcm_pkg::RST_MODE_SEL;
            st_ff.t0_lo <= dtcm_pkg::RST_COUNT;
            st_ff.t0_hi <= dtcm_pkg::RST_COUNT;
            st_ff.t1_lo <= dtcm_pkg::RST_COUNT;
            st_ff.t1_hi <= dtcm_pkg::RST_COUNT;
            // Idle-high irq pins: avoids a false edge just after reset
            st_ff.irq_s1 <= 2'h3;
            st_ff.irq_s2 <= 2'h3;
            st_ff.irq_prev <= 2'h3;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign wb_dat_o = st_ff.rdat;
    assign wb_ack_o = st_ff.ack;
    assign timer0_overflow_flag_o = st_ff.run_ctl[dtcm_pkg::B_TF0];
    assign timer1_overflow_flag_o = st_ff.run_ctl[dtcm_pkg::B_TF1];
    assign ext_irq0_flag_o = st_ff.run_ctl[dtcm_pkg::B_IE0];
    assign ext_irq1_flag_o = st_ff.run_ctl[dtcm_pkg::B_IE1];
    assign timer1_baud_tick_o = st_ff.t1_tick;

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    chk_reset_clear: assert property ($fell(rst_i) |-> st_ff.run_ctl == 8'h00)
        else $error("run control not zero after reset");

    chk_ack_single: assert property (st_ff.ack |=> !st_ff.ack)
        else $error("ack held longer than one cycle");

    chk_ack_timely: assert property (wb_cyc_i && wb_stb_i && !st_ff.ack |=> st_ff.ack)
        else $error("request not answered next cycle");

    chk_overflow_sets: assert property (set_tf0 |=> st_ff.run_ctl[dtcm_pkg::B_TF0])
        else $error("timer 0 overflow flag lost");

    chk_split_flag: assert property (t0_split && hsum[8]
        |=> st_ff.run_ctl[dtcm_pkg::B_TF1])
        else $error("split high byte overflow missed");

    chk_stop_hold: assert property (!st_ff.run_ctl[dtcm_pkg::B_TR0] && !wr
        |=> $stable(st_ff.t0_lo))
        else $error("timer 0 low byte moved while stopped");

    chk_mode3_hold: assert property (m1 == dtcm_pkg::MODE_SPLIT && !wr
        |=> $stable({st_ff.t1_hi, st_ff.t1_lo}))
        else $error("timer 1 moved in mode 3");

    chk_reload_value: assert property (m0 == dtcm_pkg::MODE_RELOAD && inc0
        && st_ff.t0_lo == 8'hFF && !wr |=> st_ff.t0_lo == $past(st_ff.t0_hi))
        else $error("reload value wrong");

    chk_full_step: assert property (m0 == dtcm_pkg::MODE_FULL && inc0 && !wr
        |=> {st_ff.t0_hi, st_ff.t0_lo} == 16'($past({st_ff.t0_hi, st_ff.t0_lo}) + 16'h0001))
        else $error("sixteen bit step wrong");

    chk_level_irq: assert property (!st_ff.run_ctl[dtcm_pkg::B_IT0] && !st_ff.irq_s2[0]
        |=> st_ff.run_ctl[dtcm_pkg::B_IE0])
        else $error("low level did not set irq flag");

    chk_tick_rate: assert property (mc_tick |=> !mc_tick)
        else $error("machine cycle tick too frequent");

    chk_overflow_t1: assert property (set_tf1
        |=> st_ff.run_ctl[dtcm_pkg::B_TF1])
        else $error("timer 1 overflow flag lost");

    chk_edge_irq0: assert property (st_ff.run_ctl[dtcm_pkg::B_IT0]
        && st_ff.irq_prev[0] && !st_ff.irq_s2[0] |=> st_ff.run_ctl[dtcm_pkg::B_IE0])
        else $error("falling edge did not set irq 0 flag");

    chk_edge_irq1: assert property (st_ff.run_ctl[dtcm_pkg::B_IT1]
        && st_ff.irq_prev[1] && !st_ff.irq_s2[1] |=> st_ff.run_ctl[dtcm_pkg::B_IE1])
        else $error("falling edge did not set irq 1 flag");

    chk_level_irq1: assert property (!st_ff.run_ctl[dtcm_pkg::B_IT1]
        && !st_ff.irq_s2[1] |=> st_ff.run_ctl[dtcm_pkg::B_IE1])
        else $error("low level did not set irq 1 flag");

    chk_prescale_carry: assert property (m0 == dtcm_pkg::MODE_PRESC && !wr
        && (st_ff.t0_lo & dtcm_pkg::PRESC_MASK) != dtcm_pkg::PRESC_MASK |=> $stable(st_ff.t0_hi))
        else $error("high byte moved before prescaler wrapped");

    chk_prescale_upper: assert property (m0 == dtcm_pkg::MODE_PRESC && !wr
        |=> $stable(st_ff.t0_lo & ~dtcm_pkg::PRESC_MASK))
        else $error("upper low-byte bits moved in 13-bit mode");

    chk_gate_hold: assert property (st_ff.mode_sel[dtcm_pkg::B_GATE0]
        && !st_ff.irq_s2[0] && !wr |=> $stable(st_ff.t0_lo))
        else $error("timer 0 counted with gate pin low");

    chk_t1_stopped: assert property (!st_ff.run_ctl[dtcm_pkg::B_TR1] && !t0_split
        && !wr |=> $stable({st_ff.t1_hi, st_ff.t1_lo}))
        else $error("timer 1 moved with run bit clear");

    chk_split_hi_step: assert property (t0_split && inc_hi && !wr
        |=> st_ff.t0_hi == 8'($past(st_ff.t0_hi) + 8'h01))
        else $error("split high byte step wrong");

    chk_baud_single: assert property (st_ff.t1_tick
        |=> !st_ff.t1_tick)
        else $error("baud tick longer than one cycle");

    chk_pin_edge: assert property (mc_tick && st_ff.cpin_samp[0]
        && !st_ff.cpin_s2[0] |=> st_ff.cpin_pend[0])
        else $error("count pin edge not noted");

    chk_reload_keeps: assert property (m0 == dtcm_pkg::MODE_RELOAD && !wr
        |=> $stable(st_ff.t0_hi))
        else $error("reload changed the high byte");

endmodule : dtcm_top

// ---- src/dtcm_pkg.sv ----
// Shared constants for the dual timer/counter block
package dtcm_pkg;

    // Register indices, byte address is four times the index
    localparam logic [7:0] IDX_RUN_CTL = 8'h88;
    localparam logic [7:0] IDX_MODE_SEL = 8'h89;
    localparam logic [7:0] IDX_T0_LO = 8'h8A;
    localparam logic [7:0] IDX_T0_HI = 8'h8B;
    localparam logic [7:0] IDX_T1_LO = 8'h8C;
    localparam logic [7:0] IDX_T1_HI = 8'h8D;
    localparam int ADR_W = 10;
    localparam int IDX_LSB = 2;

    // Run control bits
    localparam int B_TF1 = 7;
    localparam int B_TR1 = 6;
    localparam int B_TF0 = 5;
    localparam int B_TR0 = 4;
    localparam int B_IE1 = 3;
    localparam int B_IT1 = 2;
    localparam int B_IE0 = 1;
    localparam int B_IT0 = 0;

    // Mode select bits
    localparam int B_GATE1 = 7;
    localparam int B_SRC1 = 6;
    localparam int B_M1_HI = 5;
    localparam int B_M1_LO = 4;
    localparam int B_GATE0 = 3;
    localparam int B_SRC0 = 2;
    localparam int B_M0_HI = 1;
    localparam int B_M0_LO = 0;

    // Operating modes
    localparam logic [1:0] MODE_PRESC = 2'h0;
    localparam logic [1:0] MODE_FULL = 2'h1;
    localparam logic [1:0] MODE_RELOAD = 2'h2;
    localparam logic [1:0] MODE_SPLIT = 2'h3;

    // Prescaler field in the low byte
    localparam int PRESC_W = 5;
    localparam logic [7:0] PRESC_MASK = 8'h1F;

    // Reset values
    localparam logic [7:0] RST_RUN_CTL = 8'h00;
    localparam logic [7:0] RST_MODE_SEL = 8'h00;
    localparam logic [7:0] RST_COUNT = 8'h00;

    // Core clocks per machine cycle
    localparam int MC_CLKS_DEF = 6;

endpackage : dtcm_pkg

// ---- test/dtcm_pin_model.sv ----
// Far-side model of the count pins and the active-low irq/gate pins
`timescale 1ns/1ps
module dtcm_pin_model #(
    parameter int MC = 3
) (
    // Clock
    input wire logic clk_i,
    // Pins
    output logic cnt0_o = 1'b1,
    output logic cnt1_o = 1'b1,
    output logic irq0_n_o = 1'b1,
    output logic irq1_n_o = 1'b1
);
    // Each level held two machine cycles so no level escapes sampling
    task automatic pulse(input int which, input int n);
        repeat (n) begin
            @(posedge clk_i);
            if (which == 0) cnt0_o <= 1'b0; else cnt1_o <= 1'b0;
            repeat (2 * MC) @(posedge clk_i);
            if (which == 0) cnt0_o <= 1'b1; else cnt1_o <= 1'b1;
            repeat (2 * MC) @(posedge clk_i);
        end
        // Let the synchroniser and the next tick land before anyone looks
        repeat (4 * MC) @(posedge clk_i);
    endtask : pulse
    task automatic irq(input int which, input logic lvl);
        @(posedge clk_i);
        if (which == 0) irq0_n_o <= lvl; else irq1_n_o <= lvl;
        repeat (4 * MC) @(posedge clk_i);
    endtask : irq
endmodule : dtcm_pin_model

// ---- test/dtcm_tb_top.sv ----
// Self-checking bench for the dual timer/counter
`timescale 1ns/1ps
module dtcm_tb_top;
    localparam int MC = 3;
    localparam logic [7:0] RC = dtcm_pkg::IDX_RUN_CTL;
    localparam logic [7:0] MS = dtcm_pkg::IDX_MODE_SEL;
    localparam logic [7:0] T0L = dtcm_pkg::IDX_T0_LO;
    localparam logic [7:0] T0H = dtcm_pkg::IDX_T0_HI;
    localparam logic [7:0] T1L = dtcm_pkg::IDX_T1_LO;
    localparam logic [7:0] T1H = dtcm_pkg::IDX_T1_HI;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic [9:0] adr = '0;
    logic [31:0] dat = '0;
    logic [31:0] dat_o;
    logic ack, tf0, tf1, ie0, ie1, baud, p0, p1, q0_n, q1_n;
    logic [3:0] vec = 4'h0;
    logic [15:0] qexp[$];
    logic [15:0] qe, v;
    logic [31:0] r;
    int n_mismatch = 0;
    int n_checks = 0;
    always #50 clk_i = ~clk_i;
    dtcm_top #(.MC_CLKS(MC)) dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(dat),
        .wb_dat_o(dat_o), .wb_ack_o(ack), .count_pin_zero_i(p0), .count_pin_one_i(p1),
        .external_irq0_pin_n_i(q0_n), .external_irq1_pin_n_i(q1_n), .vec_tf0_i(vec[0]),
        .vec_tf1_i(vec[1]), .vec_ie0_i(vec[2]), .vec_ie1_i(vec[3]),
        .timer0_overflow_flag_o(tf0), .timer1_overflow_flag_o(tf1), .ext_irq0_flag_o(ie0),
        .ext_irq1_flag_o(ie1), .timer1_baud_tick_o(baud));
    dtcm_pin_model #(.MC(MC)) pm (.clk_i(clk_i), .cnt0_o(p0), .cnt1_o(p1),
        .irq0_n_o(q0_n), .irq1_n_o(q1_n));
    task automatic cmp(input string nm, input logic [7:0] e, input logic [7:0] m,
        input logic [7:0] g);
        n_checks++;
        if ((g & m) !== (e & m)) begin
            n_mismatch++;
            $display("mismatch %s expected %h seen %h", nm, e & m, g & m);
        end
    endtask : cmp
    // Classic cycle: hold everything until ack is sampled high
    task automatic bus(input logic [7:0] idx, input logic w, input logic [7:0] d);
        int t;
        t = 0;
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= {idx, 2'b00};
        dat <= {24'h0, d};
        do begin
            @(posedge clk_i);
            t++;
        end while (ack !== 1'b1 && t < 50);
        cyc <= 1'b0;
        stb <= 1'b0;
        if (t >= 50) begin
            n_mismatch++;
            $display("mismatch bus ack expected 1 seen 0");
            tally_and_finish();
        end
    endtask : bus
    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        bus(idx, 1'b1, d);
    endtask : wr
    task automatic rdx(input logic [7:0] idx, input logic [7:0] e, input logic [7:0] m);
        qexp.push_back({m, e});
        bus(idx, 1'b0, 8'h00);
    endtask : rdx
    task automatic vpulse(input int b);
        @(posedge clk_i);
        vec[b] <= 1'b1;
        @(posedge clk_i);
        vec[b] <= 1'b0;
        repeat (3) @(posedge clk_i);
    endtask : vpulse
    // Read data is checked in the ack cycle; the DUT holds it until the next request
    always @(posedge clk_i) begin
        if (ack === 1'b1 && we === 1'b0 && qexp.size() > 0) begin
            qe = qexp.pop_front();
            cmp("read data", qe[7:0], qe[15:8], dat_o[7:0]);
        end
    end
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : tally_and_finish
    initial begin
        #(100 * 20000);
        n_mismatch++;
        tally_and_finish();
    end
    initial begin
        r = $urandom(63);
        repeat (6) @(posedge clk_i);
        rst_i <= 1'b0;
        rdx(RC, 8'h00, 8'hFF);
        rdx(8'h90, 8'h00, 8'hFF);
        wr(MS, 8'h04);
        wr(T0L, 8'hFE);
        wr(T0H, 8'h00);
        wr(RC, 8'h10);
        pm.pulse(0, 2);
        rdx(T0L, 8'h00, 8'h1F);
        rdx(T0H, 8'h01, 8'hFF);
        wr(MS, 8'h05);
        for (int i = 0; i < 3; i++) begin
            r = $urandom();
            v = r[15:0];
            wr(RC, 8'h00);
            wr(T0L, v[7:0]);
            wr(T0H, v[15:8]);
            wr(RC, 8'h10);
            pm.pulse(0, 1 + r[17:16]);
            v = v + 16'(1 + r[17:16]);
            rdx(T0L, v[7:0], 8'hFF);
            rdx(T0H, v[15:8], 8'hFF);
        end
        wr(RC, 8'h00);
        wr(T0L, 8'hFF);
        wr(T0H, 8'hFF);
        wr(RC, 8'h10);
        pm.pulse(0, 1);
        rdx(RC, 8'h30, 8'hFF);
        vpulse(0);
        cmp("tf0", 8'h00, 8'h01, {7'h0, tf0});
        wr(MS, 8'h06);
        wr(T0H, 8'hA5);
        wr(T0L, 8'hFF);
        pm.pulse(0, 1);
        rdx(T0L, 8'hA5, 8'hFF);
        rdx(T0H, 8'hA5, 8'hFF);
        rdx(RC, 8'h30, 8'hFF);
        wr(RC, 8'h10);
        rdx(RC, 8'h10, 8'hFF);
        wr(RC, 8'h00);
        pm.pulse(0, 2);
        rdx(T0L, 8'hA5, 8'hFF);
        wr(RC, 8'h10);
        rdx(T0L, 8'hA5, 8'hFF);
        // Gate on timer 0, irq 0 in falling-edge mode
        wr(MS, 8'h0E);
        wr(RC, 8'h11);
        pm.irq(0, 1'b0);
        pm.pulse(0, 1);
        rdx(T0L, 8'hA5, 8'hFF);
        pm.irq(0, 1'b1);
        pm.pulse(0, 1);
        rdx(T0L, 8'hA6, 8'hFF);
        rdx(RC, 8'h13, 8'hFF);
        vpulse(2);
        cmp("ie0", 8'h00, 8'h01, {7'h0, ie0});
        // Low-level mode keeps the flags up while the pins are low
        wr(RC, 8'h00);
        pm.irq(0, 1'b0);
        pm.irq(1, 1'b0);
        cmp("ie0", 8'h01, 8'h01, {7'h0, ie0});
        cmp("ie1", 8'h01, 8'h01, {7'h0, ie1});
        wr(RC, 8'h00);
        cmp("ie1", 8'h01, 8'h01, {7'h0, ie1});
        pm.irq(0, 1'b1);
        pm.irq(1, 1'b1);
        wr(RC, 8'h00);
        cmp("ie0", 8'h00, 8'h01, {7'h0, ie0});
        cmp("ie1", 8'h00, 8'h01, {7'h0, ie1});
        wr(MS, 8'h70);
        wr(T1L, 8'h10);
        wr(RC, 8'h40);
        pm.pulse(1, 2);
        rdx(T1L, 8'h10, 8'hFF);
        wr(MS, 8'h50);
        pm.pulse(1, 2);
        rdx(T1L, 8'h12, 8'hFF);
        // Split timer 0; timer 1 parked in its own mode 3 while loaded
        wr(RC, 8'h00);
        wr(MS, 8'h77);
        wr(T0L, 8'hFF);
        wr(T0H, 8'hF0);
        wr(RC, 8'h50);
        pm.pulse(0, 1);
        rdx(T0L, 8'h00, 8'hFF);
        repeat (100) if (tf1 !== 1'b1) @(posedge clk_i);
        cmp("tf1", 8'h01, 8'h01, {7'h0, tf1});
        rdx(RC, 8'hA0, 8'hA0);
        wr(MS, 8'h37);
        wr(T1L, 8'hFF);
        wr(T1H, 8'hFF);
        wr(MS, 8'h17);
        repeat (60) if (baud !== 1'b1) @(posedge clk_i);
        cmp("baud tick", 8'h01, 8'h01, {7'h0, baud});
        repeat (4) @(posedge clk_i);
        tally_and_finish();
    end
endmodule : dtcm_tb_top
